// file: hdl/system_tick_timer.sv
// Purpose: System tick timer with control, reload, current value and calibration registers
// Assumes: Word access only; address carries the low 16 bits of the byte address
// Notes:   Read data appear the cycle after the read strobe and only then
//
// Function
// R1 - Control sits at 0xE010, reload at 0xE014, current value at 0xE018, calibration at 0xE01C.
// R2 - Control bit 0 enables counting.
// R3 - Control bit 1 lets the 1 to 0 step raise the exception request.
// R4 - Control bit 2 picks the reference tick when 0 and the processor clock when 1.
// R5 - With no reference tick present, the source bit is forced to 1 and reads as one.
// R6 - Status bit 16 shows a zero reached since the last read, and each read clears it.
// R7 - Reload holds 24 bits that are copied into the counter after it reaches zero.
// R8 - Flag and request fire only on the step from 1 to 0, so reload 0 gives neither.
// R9 - Software programs N-1 for a period of N counting clocks.
// R10 - Software programs reload and clears the counter before enabling it.
// R11 - Current value reads the live count; any write clears it and the zero flag.
// R12 - Calibration bits 23:0 report a read-only reload for a 10 ms period, 0 if unknown.
// R13 - Calibration bit 30 reads 1 when that 10 ms value is inexact.
// R14 - On the reference source the count advances only on the 1 us enable pulse.
// R15 - Enabled, the count steps down once per tick and reloads on the tick after zero.
// R16 - Reserved bits of the four timer registers read zero and ignore writes.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module system_tick_timer #(
	parameter logic        NO_REFERENCE  = 1'b0,
	parameter logic        CALIB_SKEW    = 1'b0,
	parameter logic [23:0] CALIB_RELOAD  = 24'h000000
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Register port
	input  wire logic [15:0] addr,
	input  wire logic [31:0] wrData,
	input  wire logic        wrStrobe,
	input  wire logic        rdStrobe,
	output logic      [31:0] rdData,
	// Reference tick, one cycle per microsecond
	input  wire logic        refTick,
	// Exception request and block interrupt
	output logic             exceptionRequest,
	output logic             irq
);
	tick_reg_if regs ();

	logic        enableReg;
	logic        excEnableReg;
	logic        sourceReg;
	logic [23:0] reloadReg;
	logic        zeroFlagReg;
	logic        excPendingReg;
	logic [1:0]  irqStatusReg;
	logic [1:0]  irqEnableReg;
	logic [31:0] rdDataNext;
	logic        wrControl;
	logic        wrReload;
	logic        wrCurrent;
	logic        rdControl;
	logic        wrIrqClear;
	logic        wrIrqEnable;
	logic        sourceNow;

	function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
		hit = (a == ofs);
	endfunction

	assign wrControl   = wrStrobe && hit(addr, tick_timer_pkg::OFS_CONTROL);   // [R1]
	assign wrReload    = wrStrobe && hit(addr, tick_timer_pkg::OFS_RELOAD);    // [R1]
	assign wrCurrent   = wrStrobe && hit(addr, tick_timer_pkg::OFS_CURRENT);   // [R1]
	assign rdControl   = rdStrobe && hit(addr, tick_timer_pkg::OFS_CONTROL);
	assign wrIrqClear  = wrStrobe && hit(addr, tick_timer_pkg::OFS_IRQ_CLEAR);
	assign wrIrqEnable = wrStrobe && hit(addr, tick_timer_pkg::OFS_IRQ_ENABLE);

	// Source bit is stuck at one when there is no reference tick
	assign sourceNow = NO_REFERENCE ? 1'b1 : sourceReg; // [R5]

	assign regs.enable      = enableReg;
	assign regs.useCpuClock = sourceNow;                // [R4]
	assign regs.refTick     = refTick;                  // [R14]
	assign regs.reloadValue = reloadReg;
	assign regs.clearCount  = wrCurrent;                // [R11]

	tick_counter_core u_core (
		.clk  (clk),
		.rst  (rst),
		.regs (regs)
	);

	always_ff @(posedge clk) begin
		if (rst) begin
			enableReg    <= tick_timer_pkg::CONTROL_RESET[tick_timer_pkg::BIT_ENABLE];
			excEnableReg <= tick_timer_pkg::CONTROL_RESET[tick_timer_pkg::BIT_EXC_ENABLE];
			sourceReg    <= tick_timer_pkg::CONTROL_RESET[tick_timer_pkg::BIT_SOURCE];
		end else if (wrControl) begin
			enableReg    <= wrData[tick_timer_pkg::BIT_ENABLE];     // [R2]
			excEnableReg <= wrData[tick_timer_pkg::BIT_EXC_ENABLE]; // [R3]
			sourceReg    <= wrData[tick_timer_pkg::BIT_SOURCE];     // [R4]
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			reloadReg <= tick_timer_pkg::COUNT_RESET;
		end else if (wrReload) begin
			reloadReg <= wrData[23:0]; // [R7]
		end
	end

	// Set wins over the read clear; a counter clear also drops the flag
	always_ff @(posedge clk) begin
		if (rst) begin
			zeroFlagReg <= 1'b0;
		end else if (regs.zeroEvent) begin
			zeroFlagReg <= 1'b1; // [R8]
		end else if (rdControl || wrCurrent) begin
			zeroFlagReg <= 1'b0; // [R6] [R11]
		end
	end

	// Exception request stays up until a control read, a current value write or clearing control bit 1
	always_ff @(posedge clk) begin
		if (rst) begin
			excPendingReg <= 1'b0;
		end else if (regs.zeroEvent && excEnableReg) begin
			excPendingReg <= 1'b1; // [R3]
		end else if (rdControl || wrCurrent || !excEnableReg) begin
			excPendingReg <= 1'b0;
		end
	end
	assign exceptionRequest = excPendingReg;

	// Block interrupt: sticky status, write-one clear, enable
	always_ff @(posedge clk) begin
		if (rst) begin
			irqStatusReg <= 2'h0;
		end else begin
			irqStatusReg <= (irqStatusReg & ~(wrIrqClear ? wrData[1:0] : 2'h0))
				| {wrCurrent, regs.zeroEvent};
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irqEnableReg <= 2'h0;
		end else if (wrIrqEnable) begin
			irqEnableReg <= wrData[1:0];
		end
	end
	assign irq = |(irqStatusReg & irqEnableReg);

	always_comb begin
		rdDataNext = 32'h0000_0000; // [R16]
		case (addr)
			tick_timer_pkg::OFS_CONTROL: begin
				rdDataNext[tick_timer_pkg::BIT_ENABLE]     = enableReg;
				rdDataNext[tick_timer_pkg::BIT_EXC_ENABLE] = excEnableReg;
				rdDataNext[tick_timer_pkg::BIT_SOURCE]     = sourceNow;   // [R5]
				rdDataNext[tick_timer_pkg::BIT_ZERO_FLAG]  = zeroFlagReg; // [R6]
			end
			tick_timer_pkg::OFS_RELOAD: begin
				rdDataNext[23:0] = reloadReg;
			end
			tick_timer_pkg::OFS_CURRENT: begin
				rdDataNext[23:0] = regs.count; // [R11]
			end
			tick_timer_pkg::OFS_CALIB: begin
				rdDataNext[tick_timer_pkg::BIT_NO_REF] = NO_REFERENCE;
				rdDataNext[tick_timer_pkg::BIT_SKEW]   = CALIB_SKEW;   // [R13]
				rdDataNext[23:0]                       = CALIB_RELOAD; // [R12]
			end
			tick_timer_pkg::OFS_IRQ_STATUS: begin
				rdDataNext[1:0] = irqStatusReg;
			end
			tick_timer_pkg::OFS_IRQ_ENABLE: begin
				rdDataNext[1:0] = irqEnableReg;
			end
			default: begin
				rdDataNext = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdData <= 32'h0000_0000;
		end else if (rdStrobe) begin
			rdData <= rdDataNext;
		end else begin
			rdData <= 32'h0000_0000;
		end
	end

	property p_flag_on_zero;
		@(posedge clk) disable iff (rst)
		regs.zeroEvent |=> zeroFlagReg;
	endproperty
	a_flag_on_zero: assert property (p_flag_on_zero) else $error("zero flag not set"); // [R6]

	property p_read_clears;
		@(posedge clk) disable iff (rst)
		(rdControl && !regs.zeroEvent) |=> (!zeroFlagReg && rdData[16] == $past(zeroFlagReg));
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("read did not return and clear flag"); // [R6]

	property p_exc_needs_enable;
		@(posedge clk) disable iff (rst)
		$rose(exceptionRequest) |-> ($past(excEnableReg) && $past(regs.zeroEvent));
	endproperty
	a_exc_needs_enable: assert property (p_exc_needs_enable) else $error("request without enable"); // [R3]

	property p_current_clear;
		@(posedge clk) disable iff (rst)
		(wrCurrent && !regs.zeroEvent) |=> (regs.count == 24'h000000 && !zeroFlagReg);
	endproperty
	a_current_clear: assert property (p_current_clear) else $error("current write did not clear"); // [R11]

	property p_source_forced;
		@(posedge clk) disable iff (rst)
		(rdStrobe && addr == tick_timer_pkg::OFS_CONTROL && NO_REFERENCE) |=> rdData[2];
	endproperty
	a_source_forced: assert property (p_source_forced) else $error("source bit not forced"); // [R5]

	property p_reload_held;
		@(posedge clk) disable iff (rst)
		wrReload |=> (reloadReg == $past(wrData[23:0]));
	endproperty
	a_reload_held: assert property (p_reload_held) else $error("reload not stored"); // [R7]

	property p_reserved_zero;
		@(posedge clk) disable iff (rst)
		rdStrobe && addr == tick_timer_pkg::OFS_RELOAD |=> rdData[31:24] == 8'h00;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero"); // [R16]

	property p_calib_read;
		@(posedge clk) disable iff (rst)
		rdStrobe && addr == tick_timer_pkg::OFS_CALIB |=> (rdData[23:0] == CALIB_RELOAD && rdData[30] == CALIB_SKEW);
	endproperty
	a_calib_read: assert property (p_calib_read) else $error("calibration read wrong"); // [R12]

	// Exception request handling
	property p_exc_clear_on_read;
		@(posedge clk) disable iff (rst)
		(rdControl && !regs.zeroEvent) |=> !exceptionRequest;
	endproperty
	a_exc_clear_on_read: assert property (p_exc_clear_on_read) else $error("request not acknowledged"); // [R3]

	property p_no_exc_disabled;
		@(posedge clk) disable iff (rst)
		!excEnableReg |=> !exceptionRequest;
	endproperty
	a_no_exc_disabled: assert property (p_no_exc_disabled) else $error("request while disabled"); // [R3]

	property p_exc_on_zero;
		@(posedge clk) disable iff (rst)
		(regs.zeroEvent && excEnableReg) |=> exceptionRequest;
	endproperty
	a_exc_on_zero: assert property (p_exc_on_zero) else $error("request not raised"); // [R3]

	// Control register storage
	property p_enable_store;
		@(posedge clk) disable iff (rst)
		wrControl |=> (enableReg == $past(wrData[0]));
	endproperty
	a_enable_store: assert property (p_enable_store) else $error("enable bit not stored"); // [R2]

	property p_source_store;
		@(posedge clk) disable iff (rst)
		(wrControl && !NO_REFERENCE) |=> (regs.useCpuClock == $past(wrData[2]));
	endproperty
	a_source_store: assert property (p_source_store) else $error("source bit not stored"); // [R4]

	property p_source_stuck;
		@(posedge clk) disable iff (rst)
		NO_REFERENCE |-> regs.useCpuClock;
	endproperty
	a_source_stuck: assert property (p_source_stuck) else $error("source bit not stuck at one"); // [R5]

	// Read port
	property p_rd_idle_zero;
		@(posedge clk) disable iff (rst)
		!rdStrobe |=> (rdData == 32'h0000_0000);
	endproperty
	a_rd_idle_zero: assert property (p_rd_idle_zero) else $error("read data outside read cycle"); // [R16]

	property p_current_read;
		@(posedge clk) disable iff (rst)
		(rdStrobe && addr == tick_timer_pkg::OFS_CURRENT) |=> (rdData == {8'h00, $past(regs.count)});
	endproperty
	a_current_read: assert property (p_current_read) else $error("current value read wrong"); // [R11]

	property p_control_reserved;
		@(posedge clk) disable iff (rst)
		(rdStrobe && addr == tick_timer_pkg::OFS_CONTROL) |=> (rdData[31:17] == 15'h0000 && rdData[15:3] == 13'h0000);
	endproperty
	a_control_reserved: assert property (p_control_reserved) else $error("control reserved bits set"); // [R16]

	property p_calib_reserved;
		@(posedge clk) disable iff (rst)
		(rdStrobe && addr == tick_timer_pkg::OFS_CALIB) |=> (rdData[29:24] == 6'h00 && rdData[31] == NO_REFERENCE);
	endproperty
	a_calib_reserved: assert property (p_calib_reserved) else $error("calibration upper bits wrong"); // [R16]

	property p_reload_read;
		@(posedge clk) disable iff (rst)
		(rdStrobe && addr == tick_timer_pkg::OFS_RELOAD) |=> (rdData[23:0] == $past(reloadReg));
	endproperty
	a_reload_read: assert property (p_reload_read) else $error("reload read wrong"); // [R7]

	// Zero flag only moves on its own events
	property p_flag_needs_event;
		@(posedge clk) disable iff (rst)
		$rose(zeroFlagReg) |-> $past(regs.zeroEvent);
	endproperty
	a_flag_needs_event: assert property (p_flag_needs_event) else $error("flag set without zero event"); // [R8]

	property p_flag_hold;
		@(posedge clk) disable iff (rst)
		(!regs.zeroEvent && !rdControl && !wrCurrent) |=> (zeroFlagReg == $past(zeroFlagReg));
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag changed without cause"); // [R6]
endmodule
`default_nettype wire

// file: hdl/tick_counter_core.sv
// Purpose: 24-bit down counter with reload
// Assumes: refTick is a one-cycle pulse synchronous to clk
// Notes:   zeroEvent pulses on the 1 to 0 step only
`timescale 1ns/1ps
`default_nettype none
module tick_counter_core (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Register side
	tick_reg_if.core  regs
);
	logic [23:0] countReg;
	logic [23:0] countNext;
	logic        step;
	tick_timer_pkg::count_state_t stateReg;

	assign step = regs.enable && (regs.useCpuClock || regs.refTick);
	assign regs.count = countReg;

	always_comb begin
		countNext = countReg;
		if (countReg == 24'h000000) begin
			countNext = regs.reloadValue;
		end else begin
			countNext = countReg - 24'h000001; // [R15]
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			countReg <= tick_timer_pkg::COUNT_RESET;
		end else if (regs.clearCount) begin
			countReg <= 24'h000000;
		end else if (step) begin
			countReg <= countNext;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			regs.zeroEvent <= 1'b0;
		end else begin
			regs.zeroEvent <= step && !regs.clearCount && (countReg == 24'h000001); // [R8]
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			stateReg <= tick_timer_pkg::CNT_IDLE;
		end else begin
			case (stateReg)
				tick_timer_pkg::CNT_IDLE: begin
					if (regs.enable) begin
						stateReg <= tick_timer_pkg::CNT_RUN;
					end
				end
				tick_timer_pkg::CNT_RUN: begin
					if (!regs.enable) begin
						stateReg <= tick_timer_pkg::CNT_IDLE;
					end
				end
				default: begin
					stateReg <= tick_timer_pkg::CNT_IDLE;
				end
			endcase
		end
	end

	property p_reload_after_zero;
		@(posedge clk) disable iff (rst)
		(step && !regs.clearCount && countReg == 24'h000000) |=> (countReg == $past(regs.reloadValue));
	endproperty
	a_reload_after_zero: assert property (p_reload_after_zero) else $error("no reload after zero"); // [R15]

	property p_hold_disabled;
		@(posedge clk) disable iff (rst)
		(!regs.enable && !regs.clearCount) |=> $stable(countReg);
	endproperty
	a_hold_disabled: assert property (p_hold_disabled) else $error("count moved while disabled"); // [R2]

	property p_ref_only;
		@(posedge clk) disable iff (rst)
		(regs.enable && !regs.useCpuClock && !regs.refTick && !regs.clearCount) |=> $stable(countReg);
	endproperty
	a_ref_only: assert property (p_ref_only) else $error("count moved without reference tick"); // [R14]

	property p_zero_cause;
		@(posedge clk) disable iff (rst)
		regs.zeroEvent |-> ($past(countReg) == 24'h000001 && countReg == 24'h000000);
	endproperty
	a_zero_cause: assert property (p_zero_cause) else $error("zero event without 1 to 0 step"); // [R8]
endmodule
`default_nettype wire

// file: hdl/tick_reg_if.sv
// Purpose: Carries the enable and source bits, reload value, reference tick and clear strobe to the counter core, and the count and zero event back
// Assumes: One clock domain
// Notes:   Strobes are single-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface tick_reg_if;
	logic        enable;
	logic        useCpuClock;
	logic        refTick;
	logic [23:0] reloadValue;
	logic        clearCount;
	logic [23:0] count;
	logic        zeroEvent;
	modport host (output enable, output useCpuClock, output refTick, output reloadValue,
		output clearCount, input count, input zeroEvent);
	modport core (input enable, input useCpuClock, input refTick, input reloadValue,
		input clearCount, output count, output zeroEvent);
endinterface
`default_nettype wire

// file: hdl/tick_timer_pkg.sv
// Purpose: Constants shared by the system tick timer files
// Assumes: 32-bit word registers at byte offsets within the private peripheral block
// Notes:   Offsets are the low 16 bits of the byte address
package tick_timer_pkg;
	localparam logic [31:0] PERIPH_BASE       = 32'hE000_0000;
	localparam logic [15:0] OFS_CONTROL       = 16'hE010;
	localparam logic [15:0] OFS_RELOAD        = 16'hE014;
	localparam logic [15:0] OFS_CURRENT       = 16'hE018;
	localparam logic [15:0] OFS_CALIB         = 16'hE01C;
	localparam logic [15:0] OFS_IRQ_STATUS    = 16'hE020;
	localparam logic [15:0] OFS_IRQ_CLEAR     = 16'hE024;
	localparam logic [15:0] OFS_IRQ_ENABLE    = 16'hE028;
	localparam int          BIT_ENABLE        = 0;
	localparam int          BIT_EXC_ENABLE    = 1;
	localparam int          BIT_SOURCE        = 2;
	localparam int          BIT_ZERO_FLAG     = 16;
	localparam int          BIT_NO_REF        = 31;
	localparam int          BIT_SKEW          = 30;
	localparam int          COUNT_WIDTH       = 24;
	localparam logic [2:0]  CONTROL_RESET     = 3'h0;
	localparam logic [23:0] COUNT_RESET       = 24'h000000;
	localparam int          IRQ_BITS          = 2;
	localparam int          IRQ_BIT_ZERO      = 0;
	localparam int          IRQ_BIT_CLEARED   = 1;
	localparam real         CLOCK_MHZ         = 40.0;
	localparam real         REF_TICK_US       = 1.0;
	localparam int          REF_TICK_CYCLES   = int'(REF_TICK_US * CLOCK_MHZ);
	localparam real         CALIB_PERIOD_MS   = 10.0;
	typedef enum logic [0:0] {
		CNT_IDLE = 1'b0,
		CNT_RUN  = 1'b1
	} count_state_t;
endpackage

// file: test/system_tick_timer_tb_top.sv
// Purpose: Self-checking bench for the system tick timer register port and count behaviour
// Assumes: 40 MHz clock; second instance built with no reference tick
// Notes:   Bus tasks drive on the rising edge and sample one step after it
`timescale 1ns/1ps
`default_nettype none
module system_tick_timer_tb_top;
	logic        clk = 1'b0;
	logic        rst;
	logic [15:0] addr;
	logic [31:0] wrData;
	logic        wrStrobe;
	logic        rdStrobe;
	logic [31:0] rdData;
	logic [31:0] rdDataAlt;
	logic        refTick;
	logic        tickOn;
	logic        exceptionRequest;
	logic        irq;
	logic [31:0] lastData;
	logic [31:0] held;
	int          failures = 0;
	int          samplesChecked = 0;
	int          cyc = 0;
	int          t1;
	int          t2;
	int          n;

	always #12.5 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	system_tick_timer #(.NO_REFERENCE(1'b0), .CALIB_SKEW(1'b1), .CALIB_RELOAD(24'h061A7F)) uut (
		.clk(clk), .rst(rst), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
		.rdData(rdData), .refTick(refTick), .exceptionRequest(exceptionRequest), .irq(irq));
	// Same bus, but no reference tick present
	system_tick_timer #(.NO_REFERENCE(1'b1)) uutNoRef (
		.clk(clk), .rst(rst), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
		.rdData(rdDataAlt), .refTick(refTick), .exceptionRequest(), .irq());
	tick_ref_source #(.PERIOD(40)) refSrc (.clk(clk), .rst(rst), .tickOn(tickOn), .refTick(refTick));

	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge clk);
		addr     <= a;
		wrData   <= d;
		wrStrobe <= 1'b1;
		@(posedge clk);
		wrStrobe <= 1'b0;
		#1;
	endtask

	task rd(input logic [15:0] a, input logic [31:0] exp, input bit doCheck = 1'b1);
		@(posedge clk);
		addr     <= a;
		rdStrobe <= 1'b1;
		@(posedge clk);
		rdStrobe <= 1'b0;
		#1;
		lastData = rdData;
		if (doCheck)
			check($sformatf("register %h", a), lastData, exp);
	endtask

	task waitExc(output int t);
		int i;
		for (i = 0; i < 40; i++) begin
			@(posedge clk);
			#1;
			if (exceptionRequest === 1'b1)
				break;
		end
		t = cyc;
		if (i == 40)
			check("exception wait", 32'h0, 32'h1);
	endtask

	task final_report;
		if (failures == 0 && samplesChecked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		final_report;
	end

	initial begin
		rst      = 1'b1;
		addr     = 16'h0;
		wrData   = 32'h0;
		wrStrobe = 1'b0;
		rdStrobe = 1'b0;
		tickOn   = 1'b0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		// Reset values, read-only calibration, reserved bits, unmapped space
		rd(tick_timer_pkg::OFS_CONTROL, 32'h0);
		rd(tick_timer_pkg::OFS_RELOAD, 32'h0);
		rd(tick_timer_pkg::OFS_CURRENT, 32'h0);
		wr(tick_timer_pkg::OFS_CALIB, 32'hFFFFFFFF);
		rd(tick_timer_pkg::OFS_CALIB, 32'h40061A7F);
		check("calibration no reference", rdDataAlt, 32'h80000000);
		wr(tick_timer_pkg::OFS_CONTROL, 32'h0);
		rd(tick_timer_pkg::OFS_CONTROL, 32'h0);
		check("source forced", rdDataAlt, 32'h4);
		wr(tick_timer_pkg::OFS_RELOAD, 32'hFFFFFFFF);
		rd(tick_timer_pkg::OFS_RELOAD, 32'h00FFFFFF);
		wr(tick_timer_pkg::OFS_CONTROL, 32'hFFFFFFF8);
		rd(tick_timer_pkg::OFS_CONTROL, 32'h0);
		rd(16'hE02C, 32'h0);
		// Processor clock counting without request, then stop and clear
		wr(tick_timer_pkg::OFS_IRQ_ENABLE, 32'h1);
		rd(tick_timer_pkg::OFS_IRQ_ENABLE, 32'h1);
		wr(tick_timer_pkg::OFS_RELOAD, 32'h9);
		wr(tick_timer_pkg::OFS_CURRENT, 32'h0);
		wr(tick_timer_pkg::OFS_CONTROL, 32'h5);
		repeat (30) @(posedge clk);
		#1;
		check("exception masked", exceptionRequest, 32'h0);
		check("irq zero event", irq, 32'h1);
		wr(tick_timer_pkg::OFS_CONTROL, 32'h0);
		rd(tick_timer_pkg::OFS_CURRENT, 32'h0, 1'b0);
		held = lastData;
		repeat (5) @(posedge clk);
		rd(tick_timer_pkg::OFS_CURRENT, held);
		rd(tick_timer_pkg::OFS_CONTROL, 32'h00010000);
		rd(tick_timer_pkg::OFS_CONTROL, 32'h0);
		rd(tick_timer_pkg::OFS_IRQ_STATUS, 32'h3);
		wr(tick_timer_pkg::OFS_IRQ_CLEAR, 32'h1);
		check("irq cleared", irq, 32'h0);
		rd(tick_timer_pkg::OFS_IRQ_STATUS, 32'h2);
		wr(tick_timer_pkg::OFS_IRQ_ENABLE, 32'h3);
		check("irq enabled", irq, 32'h1);
		wr(tick_timer_pkg::OFS_IRQ_CLEAR, 32'h2);
		check("irq off", irq, 32'h0);
		// Write to current value clears count and flag
		wr(tick_timer_pkg::OFS_CONTROL, 32'h5);
		repeat (30) @(posedge clk);
		wr(tick_timer_pkg::OFS_CONTROL, 32'h0);
		wr(tick_timer_pkg::OFS_CURRENT, 32'hDEADBEEF);
		rd(tick_timer_pkg::OFS_CONTROL, 32'h0);
		rd(tick_timer_pkg::OFS_CURRENT, 32'h0);
		// Reload of zero never reaches the 1 to 0 step
		wr(tick_timer_pkg::OFS_IRQ_CLEAR, 32'h3);
		wr(tick_timer_pkg::OFS_RELOAD, 32'h0);
		wr(tick_timer_pkg::OFS_CONTROL, 32'h7);
		repeat (20) @(posedge clk);
		#1;
		check("exception reload zero", exceptionRequest, 32'h0);
		rd(tick_timer_pkg::OFS_CONTROL, 32'h7);
		rd(tick_timer_pkg::OFS_IRQ_STATUS, 32'h0);
		// Exception request and period of reload plus one
		wr(tick_timer_pkg::OFS_RELOAD, 32'h9);
		waitExc(t1);
		rd(tick_timer_pkg::OFS_CONTROL, 32'h00010007);
		check("exception acknowledged", exceptionRequest, 32'h0);
		waitExc(t2);
		check("period", t2 - t1, 32'd10);
		// Reference source: count moves only on reference pulses
		wr(tick_timer_pkg::OFS_CONTROL, 32'h0);
		wr(tick_timer_pkg::OFS_RELOAD, 32'd100);
		wr(tick_timer_pkg::OFS_CURRENT, 32'h0);
		wr(tick_timer_pkg::OFS_CONTROL, 32'h1);
		repeat (50) @(posedge clk);
		rd(tick_timer_pkg::OFS_CURRENT, 32'h0);
		@(posedge clk);
		tickOn <= 1'b1;
		n = 0;
		for (int i = 0; i < 200 && n < 3; i++) begin
			@(posedge clk);
			#1;
			if (refTick === 1'b1)
				n++;
		end
		@(posedge clk);
		tickOn <= 1'b0;
		repeat (5) @(posedge clk);
		rd(tick_timer_pkg::OFS_CURRENT, 32'd98);
		final_report;
	end
endmodule
`default_nettype wire

// file: test/tick_ref_source.sv
// Purpose: Microsecond reference pulse source standing in for the tick generator
// Assumes: One clock, synchronous active-high reset
// Notes:   Pulses only while tickOn is high, first pulse PERIOD cycles after it rises
`timescale 1ns/1ps
`default_nettype none
module tick_ref_source #(
	parameter int PERIOD = 40
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Pulse gate
	input  wire logic tickOn,
	// One-cycle enable pulse
	output logic      refTick
);
	int phaseReg;
	always_ff @(posedge clk) begin
		if (rst || !tickOn) begin
			phaseReg <= 0;
			refTick  <= 1'b0;
		end else begin
			phaseReg <= (phaseReg == PERIOD - 1) ? 0 : phaseReg + 1;
			refTick  <= (phaseReg == PERIOD - 1);
		end
	end
endmodule
`default_nettype wire
